/* File: shared/rit_regs.svh */
// Purpose: Register indices, field positions, reset values and prescaler taps
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef RIT_REGS_SVH
`define RIT_REGS_SVH

// Register indices
`define RIT_IDX_CSR        10'h0ad
`define RIT_IDX_COUNT      10'h0ae
`define RIT_IDX_CONST      10'h0af
`define RIT_IDX_EVT_STS    10'h0b0
`define RIT_IDX_EVT_CLR    10'h0b1
`define RIT_IDX_EVT_EN     10'h0b2

// Control/status fields
`define RIT_CSR_FLAG       7
`define RIT_CSR_IE         6
`define RIT_CSR_SEL_HI     5
`define RIT_CSR_SEL_LO     3
`define RIT_CSR_ONES       3'h7

// Event bits
`define RIT_EVT_MATCH      0

// Reset values
`define RIT_RST_SEL        3'h0
`define RIT_RST_COUNT      8'h00
`define RIT_RST_CONST      8'hff

// Prescaler taps, log2 of the divide ratio per select code
`define RIT_TAP_SEL1       4'h1
`define RIT_TAP_SEL2       4'h3
`define RIT_TAP_SEL3       4'h5
`define RIT_TAP_SEL4       4'h7
`define RIT_TAP_SEL5       4'h9
`define RIT_TAP_SEL6       4'hb
`define RIT_TAP_SEL7       4'hc

`endif

/* File: shared/rit_pkg.sv */
// Purpose: Types for the refresh interval timer
// Assumes: APB with 32-bit data and 12-bit byte address
// Notes:   Whole module state travels as one packed struct
`default_nettype none

package rit_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rit_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } rit_apb_rsp_type;

  typedef enum logic {RIT_IDLE, RIT_DONE} rit_bus_state_type;

  typedef struct packed {
    rit_bus_state_type bus;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              flag;
    logic              ie;
    logic [2:0]        sel;
    logic              armed;
    logic [7:0]        cnt;
    logic [7:0]        cmp;
    logic              evt_sts;
    logic              evt_en;
    logic              irq;
  } rit_state_type;

  typedef struct packed {
    logic [11:0] pre;
    logic        tick;
  } rit_pre_state_type;

endpackage : rit_pkg

`default_nettype wire

/* File: hw/rit_prescaler.sv */
// Purpose: Free-running prescaler giving a one-cycle counting enable
// Assumes: Select code 0 stops the enable
// Notes:   Tick is registered, one cycle after the tap is reached
`include "rit_regs.svh"
`default_nettype none

module rit_prescaler
  import rit_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Control
  input  wire logic [2:0] clk_sel,
  // Enable out
  output var  logic       tick
);

  rit_pre_state_type s_q;
  rit_pre_state_type s_d;

  function automatic logic [3:0] tap_of(input logic [2:0] sel);
    case (sel)
      3'h1:    tap_of = `RIT_TAP_SEL1;
      3'h2:    tap_of = `RIT_TAP_SEL2;
      3'h3:    tap_of = `RIT_TAP_SEL3;
      3'h4:    tap_of = `RIT_TAP_SEL4;
      3'h5:    tap_of = `RIT_TAP_SEL5;
      3'h6:    tap_of = `RIT_TAP_SEL6;
      3'h7:    tap_of = `RIT_TAP_SEL7;
      default: tap_of = 4'h0;
    endcase
  endfunction : tap_of

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [11:0] mask;
    mask       = 12'(13'h1 << tap_of(clk_sel)) - 12'h1;
    s_d        = s_q;
    s_d.pre    = s_q.pre + 12'h1;
    s_d.tick   = (clk_sel != 3'h0) && ((s_q.pre & mask) == mask);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule : rit_prescaler

`default_nettype wire

/* File: hw/rit_top.sv */
// Purpose: Compare-match interval timer for refresh pacing, APB slave
// Assumes: APB master on ref_clk; one wait state per transfer
// Notes:   Register byte address is four times its index
//
// Implementation choice: the APB interface to the registers.
`include "rit_regs.svh"
`default_nettype none

// What this block does
// - Match flag raises the interrupt only while its enable bit is 1
// - Flag clears only after a read showing it 1, then a 0 write
// - Writing 1 to the flag has no effect; only hardware sets it
// - Counter equal to constant clears the counter and sets the flag
module rit_top
  import rit_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset,
  // Register bus
  input  wire rit_apb_req_type apb_req,
  output var  rit_apb_rsp_type apb_rsp,
  // Interrupt
  output var  logic            match_interrupt
);

  rit_state_type s_q;
  rit_state_type s_d;
  logic          tick;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  rit_prescaler rit_prescaler_i (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_sel (s_q.sel),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and read-back

  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == `RIT_IDX_CSR) || (idx == `RIT_IDX_COUNT) || (idx == `RIT_IDX_CONST) ||
                (idx == `RIT_IDX_EVT_STS) || (idx == `RIT_IDX_EVT_CLR) || (idx == `RIT_IDX_EVT_EN);
  endfunction : is_mapped

  function automatic logic [31:0] read_word(input logic [9:0] idx, input rit_state_type s);
    read_word = 32'h0;
    case (idx)
      `RIT_IDX_CSR:     read_word = {24'h0, s.flag, s.ie, s.sel, `RIT_CSR_ONES};
      `RIT_IDX_COUNT:   read_word = {24'h0, s.cnt};
      `RIT_IDX_CONST:   read_word = {24'h0, s.cmp};
      `RIT_IDX_EVT_STS: read_word = {31'h0, s.evt_sts};
      `RIT_IDX_EVT_EN:  read_word = {31'h0, s.evt_en};
      default:          read_word = 32'h0;
    endcase
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [9:0] idx;
  logic       done;
  logic       wr;
  logic       rd;
  logic       match_evt;

  assign idx       = apb_req.paddr[11:2];
  assign done      = apb_req.psel && apb_req.penable && (s_q.bus == RIT_DONE);
  assign wr        = done && apb_req.pwrite;
  assign rd        = done && !apb_req.pwrite;
  assign match_evt = tick && (s_q.cnt == s_q.cmp);

  always_comb
  begin
    s_d = s_q;

    case (s_q.bus)
      RIT_IDLE:
      begin
        if (apb_req.psel && apb_req.penable)
        begin
          s_d.bus     = RIT_DONE;
          s_d.prdata  = apb_req.pwrite ? 32'h0 : read_word(idx, s_q);
          s_d.pslverr = !is_mapped(idx);
        end
      end
      RIT_DONE:
      begin
        s_d.bus     = RIT_IDLE;
        s_d.prdata  = 32'h0;
        s_d.pslverr = 1'b0;
      end
      default:
        s_d.bus = RIT_IDLE;
    endcase

    // Counter
    if (tick)
      s_d.cnt = match_evt ? 8'h00 : s_q.cnt + 8'h01;
    if (wr && (idx == `RIT_IDX_COUNT))
      s_d.cnt = apb_req.pwdata[7:0];
    if (wr && (idx == `RIT_IDX_CONST))
      s_d.cmp = apb_req.pwdata[7:0];

    // Control/status register
    // Arm on the flag value that the read actually returned
    if (rd && (idx == `RIT_IDX_CSR) && s_q.prdata[`RIT_CSR_FLAG])
      s_d.armed = 1'b1;
    if (wr && (idx == `RIT_IDX_CSR))
    begin
      s_d.ie    = apb_req.pwdata[`RIT_CSR_IE];
      s_d.sel   = apb_req.pwdata[`RIT_CSR_SEL_HI:`RIT_CSR_SEL_LO];
      s_d.armed = 1'b0;
      if (s_q.armed && !apb_req.pwdata[`RIT_CSR_FLAG])
        s_d.flag = 1'b0;
    end
    if (match_evt)
      s_d.flag = 1'b1;

    // Event status, clear and enable
    if (wr && (idx == `RIT_IDX_EVT_EN))
      s_d.evt_en = apb_req.pwdata[`RIT_EVT_MATCH];
    if (wr && (idx == `RIT_IDX_EVT_CLR) && apb_req.pwdata[`RIT_EVT_MATCH])
      s_d.evt_sts = 1'b0;
    if (match_evt)
      s_d.evt_sts = 1'b1;

    s_d.irq = (s_d.flag && s_d.ie) || (s_d.evt_sts && s_d.evt_en);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q         <= '0;
      s_q.bus     <= RIT_IDLE;
      s_q.sel     <= `RIT_RST_SEL;
      s_q.cnt     <= `RIT_RST_COUNT;
      s_q.cmp     <= `RIT_RST_CONST;
    end
    else
      s_q <= s_d;
  end

  assign apb_rsp.pready   = (s_q.bus == RIT_DONE);
  assign apb_rsp.prdata   = s_q.prdata;
  assign apb_rsp.pslverr  = s_q.pslverr;
  assign match_interrupt  = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_stop_no_tick: assert property (
    (s_q.sel == 3'h0) && ($past(s_q.sel) == 3'h0) |-> !tick)
    else $error("Counting enable seen while clock select is stopped");

  chk_div2_rate: assert property (
    (s_q.sel == 3'h1) && ($past(s_q.sel) == 3'h1) && tick |=> !tick ##1 (tick || (s_q.sel != 3'h1)))
    else $error("Divide by two enable rate wrong");

  chk_irq_gated: assert property (
    !(s_q.flag && s_q.ie) && !(s_q.evt_sts && s_q.evt_en) |-> !match_interrupt)
    else $error("Interrupt raised with no enabled source");

  chk_irq_raised: assert property (
    s_q.flag && s_q.ie |-> match_interrupt)
    else $error("Enabled match flag did not raise the interrupt");

  chk_clear_after_read: assert property (
    $fell(s_q.flag) |-> $past(s_q.armed) && $past(wr) && !$past(match_evt))
    else $error("Flag cleared without read-then-write sequence");

  chk_flag_hw_only: assert property (
    $rose(s_q.flag) |-> $past(match_evt))
    else $error("Flag set by something other than a match");

  chk_match_clears: assert property (
    match_evt |=> s_q.flag && s_q.evt_sts &&
                  ((s_q.cnt == 8'h00) || ($past(wr) && ($past(idx) == `RIT_IDX_COUNT))))
    else $error("Match did not clear counter and set flag");

  chk_low_bits_ones: assert property (
    apb_rsp.pready && !$past(apb_req.pwrite) && ($past(idx) == `RIT_IDX_CSR) |-> apb_rsp.prdata[2:0] == 3'h7)
    else $error("Low status bits did not read as ones");

endmodule : rit_top

`default_nettype wire

/* File: dv/tb_rit_top.sv */
// Purpose: Self-checking bench for the refresh interval timer
// Assumes: APB master on ref_clk; byte address is four times the index
// Notes:   Directed tests, no random stimulus
`include "rit_regs.svh"
`default_nettype none

module tb_rit_top
  import rit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] CSR = {`RIT_IDX_CSR, 2'b00};
  localparam logic [11:0] CNT = {`RIT_IDX_COUNT, 2'b00};
  localparam logic [11:0] CST = {`RIT_IDX_CONST, 2'b00};
  localparam logic [11:0] STS = {`RIT_IDX_EVT_STS, 2'b00};
  localparam logic [11:0] CLR = {`RIT_IDX_EVT_CLR, 2'b00};
  localparam logic [11:0] EN  = {`RIT_IDX_EVT_EN, 2'b00};
  localparam logic [11:0] BAD = {10'h0b3, 2'b00};
  localparam int          DIV [8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};

  logic            ref_clk;
  logic            reset;
  rit_apb_req_type req;
  rit_apb_rsp_type rsp;
  logic            irq;
  logic [31:0]     rd;
  logic [31:0]     hold;
  logic            err;
  int              n_fail;
  int              total_checks;
  int              cyc = 0;

  rit_top rit_top_i (
    .ref_clk         (ref_clk),
    .reset           (reset),
    .apb_req         (req),
    .apb_rsp         (rsp),
    .match_interrupt (irq)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks: %0d mismatches: %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : xfer

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic irqc(input logic exp);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irqc

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      n_fail++;
      $display("ERROR at %0t: timeout", $time);
      finish_test();
    end
  end

  initial
  begin
    req = '0;
    reset = 1'b1;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(CSR, 32'h07);
    rdc(CST, 32'hff);
    rdc(CNT, 32'h00);
    chk({31'h0, err}, 32'h0);
    xfer(1'b1, CSR, 32'hff);
    rdc(CSR, 32'h7f);
    xfer(1'b1, CSR, 32'h00);
    rdc(CSR, 32'h07);
    for (int s = 1; s < 8; s++)
    begin
      xfer(1'b1, CSR, 32'(s << 3));
      xfer(1'b1, CNT, 32'h0);
      repeat (8 * DIV[s]) @(posedge ref_clk);
      xfer(1'b0, CNT, 32'h0);
      chk({31'h0, rd >= 32'h7 && rd <= 32'ha}, 32'h1);
    end
    xfer(1'b1, CSR, 32'h00);
    xfer(1'b0, CNT, 32'h0);
    hold = rd;
    repeat (100) @(posedge ref_clk);
    rdc(CNT, hold);
    xfer(1'b1, CST, 32'h03);
    xfer(1'b1, CNT, 32'h0);
    xfer(1'b1, CSR, 32'h48);
    repeat (20) @(posedge ref_clk);
    xfer(1'b1, CSR, 32'hc0);
    irqc(1'b1);
    rdc(CSR, 32'hc7);
    xfer(1'b0, CNT, 32'h0);
    chk({31'h0, rd <= 32'h3}, 32'h1);
    xfer(1'b1, CSR, 32'hc0);
    xfer(1'b1, CSR, 32'h40);
    rdc(CSR, 32'hc7);
    xfer(1'b1, CSR, 32'h00);
    rdc(CSR, 32'h07);
    irqc(1'b0);
    xfer(1'b1, CNT, 32'h0);
    xfer(1'b1, CSR, 32'h08);
    repeat (20) @(posedge ref_clk);
    xfer(1'b1, CSR, 32'h00);
    rdc(CSR, 32'h87);
    irqc(1'b0);
    xfer(1'b1, STS, 32'h0);
    rdc(STS, 32'h1);
    xfer(1'b1, EN, 32'h1);
    irqc(1'b1);
    xfer(1'b1, CLR, 32'h1);
    rdc(STS, 32'h0);
    irqc(1'b0);
    xfer(1'b1, BAD, 32'hff);
    chk({31'h0, err}, 32'h1);
    rdc(BAD, 32'h0);
    chk({31'h0, err}, 32'h1);
    finish_test();
  end

endmodule : tb_rit_top

`default_nettype wire
